// *** logic/sysid_lowvolt_top.sv ***
// apb register bank: device id and low-voltage detect control
`timescale 1ns/10ps
`default_nettype none
`include "lowvolt_map_regs.svh"
module sysid_lowvolt_top
	import sysid_lowvolt_pkg::*;
#(
	// arbitrary neutral part id
	parameter logic [11:0] PART_ID = 12'h5a3,
	// value shown in the reserved id nibble
	parameter logic [3:0] ID_RSV_VAL = 4'h0
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog detector and power modes
	input wire logic lv_detect_in,
	input wire logic stop_mode,
	input wire logic stop2_wake,
	output logic lv_detector_en,
	output logic bandgap_buf_en,
	// requests
	output logic lowvolt_irq,
	output logic mcu_reset_req,
	output logic irq
);
	logic lv_sync;
	logic setup;
	logic wr_fire;
	logic lv_wr;
	logic ist_wr;
	logic imsk_wr;
	logic flag_set;
	logic detect_on;
	logic wo_viol;
	reg_sel_e sel;
	byte_t wb;
	byte_t rd_byte;
	byte_t lvcs_rd;
	logic flag_q;
	logic ie_q;
	logic se_q;
	logic bg_q;
	logic re_q;
	logic me_q;
	logic re_locked;
	logic me_locked;
	logic pready_q;
	logic pslverr_q;
	word_t prdata_q;
	logic lowvolt_irq_q;
	logic mcu_reset_req_q;
	logic lv_detector_en_q;
	logic irq_q;
	logic [`IRQ_W-1:0] ist_q;
	logic [`IRQ_W-1:0] imsk_q;
	logic [`IRQ_W-1:0] ev;

	// detector output is asynchronous to the bus clock
	lowvolt_sync2 u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.async_in(lv_detect_in),
		.sync_out(lv_sync)
	);

	// bus decode; only byte lane 0 carries register data
	assign sel = decode(paddr);
	assign setup = psel && !penable;
	assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;
	assign wb = pwdata[7:0];
	assign lv_wr = wr_fire && (sel == SEL_LVCS) && pstrb[0];
	assign ist_wr = wr_fire && (sel == SEL_IRQ_STATUS) && pstrb[0];
	assign imsk_wr = wr_fire && (sel == SEL_IRQ_MASK) && pstrb[0];

	// write-once master and reset enables
	write_once_bit #(
		.RST_VAL(`RST_LV_ME)
	) u_me (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.we(lv_wr),
		.d(wb[`LV_ME_BIT]),
		.q(me_q),
		.locked(me_locked)
	);

	write_once_bit #(
		.RST_VAL(`RST_LV_RE)
	) u_re (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.we(lv_wr),
		.d(wb[`LV_RE_BIT]),
		.q(re_q),
		.locked(re_locked)
	);

	// plain read/write enables; stop2 wakeup touches none of them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ie_q <= `RST_LV_IE;
			se_q <= `RST_LV_SE;
			bg_q <= `RST_LV_BG;
		end else if (ce && lv_wr) begin
			ie_q <= wb[`LV_IE_BIT];
			se_q <= wb[`LV_SE_BIT];
			bg_q <= wb[`LV_BG_BIT];
		end
	end

	// detection runs in stop only with stop enable set
	assign detect_on = me_q && (!stop_mode || se_q);
	assign flag_set = lv_sync && detect_on;

	// set beats a simultaneous acknowledge so no event is lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (ce) begin
			if (flag_set) begin
				flag_q <= 1'b1;
			end else if (lv_wr && wb[`LV_ACK_BIT]) begin
				flag_q <= 1'b0;
			end
		end
	end

	// registered requests to the system
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lowvolt_irq_q <= 1'b0;
			mcu_reset_req_q <= 1'b0;
			lv_detector_en_q <= 1'b0;
		end else if (ce) begin
			lowvolt_irq_q <= flag_q && ie_q;
			mcu_reset_req_q <= flag_q && re_q && me_q;
			lv_detector_en_q <= detect_on;
		end
	end

	// sticky events: flag rising, rejected write-once write
	assign wo_viol = lv_wr && me_locked && re_locked;
	assign ev[`IRQ_LV_BIT] = flag_set && !flag_q;
	assign ev[`IRQ_WO_BIT] = wo_viol;

	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_W; gi++) begin : g_ist
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					ist_q[gi] <= 1'b0;
				end else if (ce) begin
					if (ev[gi]) begin
						ist_q[gi] <= 1'b1;
					end else if (ist_wr && wb[gi]) begin
						ist_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			imsk_q <= `RST_IRQ;
		end else if (ce && imsk_wr) begin
			imsk_q <= wb[`IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= |(ist_q & imsk_q);
		end
	end

	// read view; ack and reserved bit always read zero
	always_comb begin
		lvcs_rd = 8'h00;
		lvcs_rd[`LV_FLAG_BIT] = flag_q;
		lvcs_rd[`LV_IE_BIT] = ie_q;
		lvcs_rd[`LV_RE_BIT] = re_q;
		lvcs_rd[`LV_SE_BIT] = se_q;
		lvcs_rd[`LV_ME_BIT] = me_q;
		lvcs_rd[`LV_BG_BIT] = bg_q;
	end

	always_comb begin
		case (sel)
			SEL_ID_HIGH: rd_byte = {ID_RSV_VAL, PART_ID[11:8]};
			SEL_ID_LOW: rd_byte = PART_ID[7:0];
			SEL_LVCS: rd_byte = lvcs_rd;
			SEL_IRQ_STATUS: rd_byte = {6'h00, ist_q};
			SEL_IRQ_MASK: rd_byte = {6'h00, imsk_q};
			default: rd_byte = 8'h00;
		endcase
	end

	// answer in the first access cycle: data latched in setup
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else if (ce) begin
			pready_q <= setup;
			pslverr_q <= setup && (sel == SEL_NONE);
			if (setup && !pwrite) begin
				prdata_q <= {24'h0, rd_byte};
			end else begin
				prdata_q <= 32'h0;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign lowvolt_irq = lowvolt_irq_q;
	assign mcu_reset_req = mcu_reset_req_q;
	assign lv_detector_en = lv_detector_en_q;
	assign bandgap_buf_en = bg_q;
	assign irq = irq_q;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	flag_sets_a: assert property (
		ce && flag_set |=> flag_q)
		else $error("flag not set on detect event");

	flag_gated_a: assert property (
		ce && !flag_q && !detect_on |=> !flag_q)
		else $error("flag set while detection off");

	ack_clears_a: assert property (
		ce && lv_wr && wb[`LV_ACK_BIT] && !flag_set |=> !flag_q)
		else $error("ack did not clear flag");

	ack_reads_a: assert property (
		pready_q && psel && !pwrite && sel == SEL_LVCS
		|-> prdata_q[`LV_ACK_BIT] == 1'b0 && prdata_q[`LV_RSV_BIT] == 1'b0)
		else $error("ack or reserved bit read nonzero");

	id_value_a: assert property (
		pready_q && psel && !pwrite && sel == SEL_ID_LOW
		|-> prdata_q[7:0] == PART_ID[7:0])
		else $error("id low wrong");

	id_nibble_a: assert property (
		pready_q && psel && !pwrite && sel == SEL_ID_HIGH
		|-> prdata_q[7:0] == {ID_RSV_VAL, PART_ID[11:8]})
		else $error("id high wrong");

	irq_path_a: assert property (
		ce && flag_q && ie_q && !lv_wr ##1 ce |-> lowvolt_irq_q)
		else $error("low-voltage interrupt missing");

	irq_off_a: assert property (
		ce && !ie_q && !lv_wr |=> !lowvolt_irq_q)
		else $error("interrupt with enable low");

	reset_req_a: assert property (
		ce && flag_q && re_q && me_q |=> mcu_reset_req_q)
		else $error("reset request missing");

	reset_off_a: assert property (
		ce && !re_q |=> !mcu_reset_req_q)
		else $error("reset request with enable low");

	stop_gate_a: assert property (
		ce && stop_mode && !se_q |=> !lv_detector_en_q)
		else $error("detector on in stop");

	bandgap_wr_a: assert property (
		ce && lv_wr |=> bandgap_buf_en == $past(wb[`LV_BG_BIT]))
		else $error("bandgap enable not written");

	once_hold_a: assert property (
		ce && lv_wr && me_locked |=> me_q == $past(me_q) && re_q == $past(re_q))
		else $error("write-once bit changed twice");

	stop2_keep_a: assert property (
		ce && stop2_wake && !lv_wr && !flag_set
		|=> $stable({flag_q, ie_q, se_q, bg_q, re_q, me_q}))
		else $error("stop2 wakeup changed control state");

	flag_hold_a: assert property (
		ce && flag_q && !(lv_wr && wb[`LV_ACK_BIT]) |=> flag_q)
		else $error("flag dropped without acknowledge");

	me_gate_a: assert property (
		ce && !me_q |=> !lv_detector_en_q)
		else $error("detector on with master enable low");

	reset_me_a: assert property (
		ce && !me_q |=> !mcu_reset_req_q)
		else $error("reset request with master enable low");

	once_lock_a: assert property (
		ce && lv_wr && !me_locked |=> me_locked && re_locked
		&& me_q == $past(wb[`LV_ME_BIT]) && re_q == $past(wb[`LV_RE_BIT]))
		else $error("write-once bits not taken on first write");

	stop_run_a: assert property (
		ce && me_q && stop_mode && se_q |=> lv_detector_en_q)
		else $error("detector off in stop with stop enable");

	ist_clear_a: assert property (
		ce && ist_wr && wb[`IRQ_LV_BIT] && !ev[`IRQ_LV_BIT] |=> !ist_q[`IRQ_LV_BIT])
		else $error("status bit not cleared by write one");

	irq_out_a: assert property (
		ce && |(ist_q & imsk_q) |=> irq_q)
		else $error("interrupt output missing");

	pready_once_a: assert property (
		ce && pready_q |=> !pready_q)
		else $error("ready held longer than one cycle");

	flag_cov_c: cover property (ce && flag_set && !flag_q);
	ack_cov_c: cover property (flag_q ##1 lv_wr && wb[`LV_ACK_BIT] ##1 !flag_q);
	reset_cov_c: cover property (mcu_reset_req_q);
	irq_cov_c: cover property (irq_q && lowvolt_irq_q);
	wonce_cov_c: cover property (ce && wo_viol);
endmodule
`default_nettype wire

// *** logic/lowvolt_map_regs.svh ***
// register offsets, field positions and reset values of the id and lvd bank
`ifndef LOWVOLT_MAP_REGS_SVH
`define LOWVOLT_MAP_REGS_SVH

`define OFS_ID_HIGH 8'h00
`define OFS_ID_LOW 8'h04
`define OFS_LVCS 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10

`define LV_FLAG_BIT 7
`define LV_ACK_BIT 6
`define LV_IE_BIT 5
`define LV_RE_BIT 4
`define LV_SE_BIT 3
`define LV_ME_BIT 2
`define LV_RSV_BIT 1
`define LV_BG_BIT 0

`define RST_LV_IE 1'b0
`define RST_LV_RE 1'b1
`define RST_LV_SE 1'b1
`define RST_LV_ME 1'b1
`define RST_LV_BG 1'b0

`define IRQ_LV_BIT 0
`define IRQ_WO_BIT 1
`define IRQ_W 2
`define RST_IRQ 2'h0

`endif

// *** logic/sysid_lowvolt_pkg.sv ***
// types and address decode shared by the id and lvd bank
`include "lowvolt_map_regs.svh"
package sysid_lowvolt_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [31:0] word_t;
	typedef enum logic [2:0] {
		SEL_ID_HIGH = 3'b000,
		SEL_ID_LOW = 3'b001,
		SEL_LVCS = 3'b010,
		SEL_IRQ_STATUS = 3'b011,
		SEL_IRQ_MASK = 3'b100,
		SEL_NONE = 3'b111
	} reg_sel_e;

	function automatic reg_sel_e decode(input logic [11:0] addr);
		reg_sel_e s;
		s = SEL_NONE;
		if (addr[11:8] == 4'h0) begin
			case (addr[7:0])
				`OFS_ID_HIGH: s = SEL_ID_HIGH;
				`OFS_ID_LOW: s = SEL_ID_LOW;
				`OFS_LVCS: s = SEL_LVCS;
				`OFS_IRQ_STATUS: s = SEL_IRQ_STATUS;
				`OFS_IRQ_MASK: s = SEL_IRQ_MASK;
				default: s = SEL_NONE;
			endcase
		end
		return s;
	endfunction
endpackage

// *** logic/lowvolt_sync2.sv ***
// two-flop synchroniser for the analog detector level
`timescale 1ns/10ps
`default_nettype none
module lowvolt_sync2 (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end else if (ce) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** logic/write_once_bit.sv ***
// control bit that takes only the first write after reset
`timescale 1ns/10ps
`default_nettype none
module write_once_bit #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// write side
	input wire logic we,
	input wire logic d,
	// state
	output logic q,
	output logic locked
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= RST_VAL;
			locked <= 1'b0;
		end else if (ce && we && !locked) begin
			q <= d;
			locked <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** dv/lowvolt_detector_model.sv ***
// analog low-voltage detector and bandgap buffer stand-in
`timescale 1ns/10ps
`default_nettype none
module lowvolt_detector_model (
	// stimulus from the bench
	input wire logic supply_low,
	// controls from the block
	input wire logic lv_detector_en,
	input wire logic bandgap_buf_en,
	// analog side outputs
	output logic lv_detect_in,
	output logic ref_ok
);
	// a powered-down detector never trips, so it reads low
	always_comb begin
		lv_detect_in = supply_low & lv_detector_en;
	end
	// regulator assumed on, so the reference is good whenever the buffer is enabled
	always_comb begin
		ref_ok = bandgap_buf_en;
	end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the id and low-voltage register bank
`timescale 1ns/10ps
`default_nettype none
`include "lowvolt_map_regs.svh"
`define chk(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
$display("Error at %0t: got %h exp %h", $time, a, e); end end
module tb_top;
	import sysid_lowvolt_pkg::*;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, lv_in, stop_mode = 0, wake = 0, lv_en, bg_en;
	logic lv_irq, rst_req, irq, low = 0, ref_ok, ce = 1;
	logic [31:0] rdv;
	logic errv;
	int mismatches = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	sysid_lowvolt_top dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lv_detect_in(lv_in), .stop_mode(stop_mode), .stop2_wake(wake),
		.lv_detector_en(lv_en), .bandgap_buf_en(bg_en),
		.lowvolt_irq(lv_irq), .mcu_reset_req(rst_req), .irq(irq));
	lowvolt_detector_model det (.supply_low(low), .lv_detector_en(lv_en),
		.bandgap_buf_en(bg_en), .lv_detect_in(lv_in), .ref_ok(ref_ok));
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(0, a, 8'h00);
		`chk(rdv, {24'h0, e})
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic do_reset;
		@(posedge clk);
		rst <= 1;
		wt(12);
		rst <= 0;
		wt(2);
	endtask
	task automatic t_reset;
		`chk(bg_en, 1'b0)
		`chk(lv_en, 1'b1)
		rd(`OFS_ID_HIGH, 8'h05);
		rd(`OFS_ID_LOW, 8'ha3);
		rd(`OFS_LVCS, 8'h1c);
	endtask
	task automatic t_id_ro;
		apb(1, `OFS_ID_HIGH, 8'hff);
		apb(1, `OFS_ID_LOW, 8'h00);
		rd(`OFS_ID_HIGH, 8'h05);
		rd(`OFS_ID_LOW, 8'ha3);
		apb(1, 12'h014, 8'h01);
		`chk(errv, 1'b1)
		rd(12'h800, 8'h00);
		`chk(errv, 1'b1)
	endtask
	task automatic t_reset_req;
		low <= 1;
		wt(6);
		`chk(rst_req, 1'b1)
		`chk(lv_irq, 1'b0)
		rd(`OFS_LVCS, 8'h9c);
		low <= 0;
		wt(4);
		@(posedge clk) wake <= 1;
		@(posedge clk) wake <= 0;
		rd(`OFS_LVCS, 8'h9c);
	endtask
	task automatic t_wonce;
		apb(1, `OFS_LVCS, 8'h2d);
		rd(`OFS_LVCS, 8'h2d);
		`chk(bg_en, 1'b1)
		`chk(ref_ok, 1'b1)
		apb(1, `OFS_LVCS, 8'h11);
		rd(`OFS_LVCS, 8'h05);
		rd(`OFS_IRQ_STATUS, 8'h02);
		apb(1, `OFS_LVCS, 8'h2d);
		apb(1, `OFS_IRQ_STATUS, 8'h03);
	endtask
	task automatic t_irq;
		apb(1, `OFS_IRQ_MASK, 8'h01);
		low <= 1;
		wt(6);
		`chk(lv_irq, 1'b1)
		`chk(irq, 1'b1)
		`chk(rst_req, 1'b0)
		rd(`OFS_LVCS, 8'had);
		low <= 0;
		wt(4);
		apb(1, `OFS_LVCS, 8'h6d);
		rd(`OFS_LVCS, 8'h2d);
		`chk(lv_irq, 1'b0)
		apb(1, `OFS_IRQ_STATUS, 8'h01);
		wt(2);
		`chk(irq, 1'b0)
	endtask
	task automatic t_stop;
		apb(1, `OFS_LVCS, 8'h25);
		stop_mode <= 1;
		wt(3);
		`chk(lv_en, 1'b0)
		low <= 1;
		wt(6);
		rd(`OFS_LVCS, 8'h25);
		stop_mode <= 0;
		wt(8);
		`chk(lv_en, 1'b1)
		rd(`OFS_LVCS, 8'ha5);
		low <= 0;
		wt(4);
		apb(1, `OFS_LVCS, 8'h65);
		rd(`OFS_LVCS, 8'h25);
	endtask
	task automatic t_hold;
		ce <= 0;
		low <= 1;
		wt(8);
		`chk(lv_irq, 1'b0)
		ce <= 1;
		wt(6);
		`chk(lv_irq, 1'b1)
		rd(`OFS_LVCS, 8'ha5);
		low <= 0;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		do_reset();
		t_reset();
		t_id_ro();
		t_reset_req();
		do_reset();
		t_wonce();
		t_irq();
		t_stop();
		t_hold();
		test_done();
	end
	// bench needs a few hundred cycles; this is far beyond it
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
